/* pin_share_pkg.sv */
// Package for the video port pin sharing block: register map, field
// positions, reset values, lane numbering and the pad carrier type.
// Assumes a 32-bit APB master and byte addresses as printed.
package pin_share_pkg;

   localparam logic [31:0] VIDEO_SHARE_ADDR = 32'h8000_1400;
   localparam logic [31:0] DEBUG_MODE_ADDR = 32'h8000_1404;
   localparam logic [31:0] ROUTING_ADDR = 32'h8000_1408;
   localparam logic [31:0] ROUTE_STATUS_ADDR = 32'h8000_1410;
   localparam logic [31:0] DIR_LOW_ADDR = 32'h8000_1C40;
   localparam logic [31:0] DIR_HIGH_ADDR = 32'h8000_1C44;

   // Writable bits; everything else reads as zero
   localparam logic [31:0] VIDEO_SHARE_MASK = 32'h8000_0000;
   localparam logic [31:0] DEBUG_MODE_MASK = 32'h4000_0000;
   localparam logic [31:0] ROUTING_MASK = 32'hC0FF_0000;
   localparam logic [31:0] DIR_LOW_MASK = 32'hFFFF_FFFF;
   localparam logic [31:0] DIR_HIGH_MASK = 32'h00FF_FFFF;

   // Debug set at reset keeps every debug-gated lane on video
   localparam logic [31:0] VIDEO_SHARE_RST = 32'h0000_0000;
   localparam logic [31:0] DEBUG_MODE_RST = 32'h4000_0000;
   localparam logic [31:0] ROUTING_RST = 32'h0000_0000;
   localparam logic [31:0] DIR_RST = 32'h0000_0000;

   localparam int VIDEO_IN_OUT_SHARE_BIT = 31;
   localparam int DEBUG_BIT = 30;
   localparam int GPIO_VO1_BIT = 31;
   localparam int GPIO_VO0_BIT = 30;
   localparam int GPIO_VO3_LSB = 21;
   localparam logic [2:0] GPIO_VO3_CODE = 3'h1;
   localparam int GPIO_VO2_BIT = 20;
   localparam int SECOND_SERIAL_BIT = 19;
   localparam int FIRST_SERIAL_BIT = 18;
   localparam int VIDEO_OUT_SHARE_BIT = 17;
   localparam int VIDEO_IN2_SHARE_BIT = 16;
   localparam logic [2:0] SERIAL_FIELD_CLEAR = 3'h0;

   // Lane k carries general-purpose byte k
   localparam int LANES = 7;
   localparam int LANE_VO2 = 0;
   localparam int LANE_VO1 = 1;
   localparam int LANE_VO0 = 2;
   localparam int LANE_VI3 = 3;
   localparam int LANE_VI2 = 4;
   localparam int LANE_VI1 = 5;
   localparam int LANE_VO3 = 6;
   localparam logic [LANES-1:0] LANE_IS_VIDEO_OUT = 7'h47;

   // Serial bits inside the video-in-3 lane
   localparam int SECOND_TX_PIN = 3;
   localparam int SECOND_RX_PIN = 2;
   localparam int FIRST_TX_PIN = 1;
   localparam int FIRST_RX_PIN = 0;

   localparam int STATUS_LANE_LSB = 0;
   localparam int STATUS_FIRST_TX_BIT = 8;
   localparam int STATUS_SECOND_TX_BIT = 9;

   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] enable;
   } pad_lane_t;

   typedef enum {
      SEL_SHARE,
      SEL_DEBUG,
      SEL_ROUTE,
      SEL_STATUS,
      SEL_DIR_LOW,
      SEL_DIR_HIGH,
      SEL_NONE
   } reg_sel_t;

endpackage

/* apb_reg_port.sv */
// APB address decode for the pin sharing registers.
// Assumes an APB3 master; zero wait states, error on unmapped addresses.
`timescale 1ns/100ps
`default_nettype none
module apb_reg_port
   import pin_share_pkg::*;
(
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   output reg_sel_t sel,
   output logic wr_en,
   output logic pready,
   output logic pslverr
);

   always_comb
   begin
      unique case (paddr)
         VIDEO_SHARE_ADDR: sel = SEL_SHARE;
         DEBUG_MODE_ADDR: sel = SEL_DEBUG;
         ROUTING_ADDR: sel = SEL_ROUTE;
         ROUTE_STATUS_ADDR: sel = SEL_STATUS;
         DIR_LOW_ADDR: sel = SEL_DIR_LOW;
         DIR_HIGH_ADDR: sel = SEL_DIR_HIGH;
         default: sel = SEL_NONE;
      endcase
   end

   // Every access finishes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && (sel == SEL_NONE);
   assign wr_en = psel && penable && pwrite && (sel != SEL_NONE);

endmodule
`default_nettype wire

/* pad_lane_mux.sv */
// One byte of shared pads: picks per bit between the video function and
// the alternate function, registered toward the pad.
// Assumes pad outputs are resolved to a wire outside this block.
`timescale 1ns/100ps
`default_nettype none
module pad_lane_mux
   import pin_share_pkg::*;
#(
   parameter logic VIDEO_IS_OUTPUT = 1'b1
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] alt_sel,
   input wire logic [7:0] video_drive,
   input wire logic [7:0] alt_drive,
   input wire logic [7:0] alt_enable,
   output pad_lane_t pad
);

   localparam logic [7:0] VIDEO_ENABLE = {8{VIDEO_IS_OUTPUT}};

   pad_lane_t pad_d;

   always_comb
   begin
      pad_d.drive = (alt_sel & alt_drive) | (~alt_sel & video_drive);
      pad_d.enable = (alt_sel & alt_enable) | (~alt_sel & VIDEO_ENABLE);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pad.drive <= 8'h00;
         pad.enable <= VIDEO_ENABLE;
      end
      else
      begin
         pad <= pad_d;
      end
   end

endmodule
`default_nettype wire

/* video_port_pin_sharing_mux.sv */
// Pin sharing control: APB registers that decide whether video port data
// pads carry video, two serial channels or 56 general-purpose pins.
// Assumes pads, serial engines and the general-purpose engine sit outside.
//
// Notes on behaviour
// - Routing bit 19 puts second serial port on video-in-3 bits 3 and 2.
// - Routing bit 18 puts first serial port on video-in-3 bits 1 and 0.
// - Serial transmit routing only works while video-out share bit 17 is low.
// - Debug bit 30 high keeps debug-gated serial and general-purpose lanes off.
// - Pins 7..0 on video-out-2 when debug low and routing bit 20 high.
// - Direction bit one makes a pin output, zero makes it input.
// - Pins 15..8 on video-out-1 when routing bit 31 and share bit match.
// - Share bit polarity is ambiguous; a parameter picks it.
// - Pins 23..16 on video-out-0 when routing bit 30 and share bit match.
// - Pins 31..24 on video-in-3 when debug low and bits 19..17 zero.
// - Pins 39..32 on video-in-2 when debug low and routing bit 16 low.
// - Pins 47..40 on video-in-1 whenever debug is low.
// - Pins 55..48 on video-out-3 when routing bits 23..21 equal one.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module video_port_pin_sharing_mux
   import pin_share_pkg::*;
#(
   // Pad table and field text disagree; table value is the default
   parameter logic VIDEO_SHARE_POLARITY = 1'b1
)
(
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [7:0] SHARED_PAD_IN [LANES],
   output pad_lane_t SHARED_PAD [LANES],
   input wire logic [7:0] VIDEO_DRIVE [LANES],
   input wire logic [55:0] GPIO_DRIVE,
   output logic [55:0] GPIO_SENSE,
   input wire logic FIRST_SERIAL_TRANSMIT,
   output logic FIRST_SERIAL_RECEIVE,
   input wire logic SECOND_SERIAL_TRANSMIT,
   output logic SECOND_SERIAL_RECEIVE
);

   reg_sel_t sel;
   logic wr_en;
   logic [31:0] video_share_select_q;
   logic [31:0] debug_mode_select_q;
   logic [31:0] pin_function_routing_q;
   logic [31:0] dir_low_q;
   logic [31:0] dir_high_q;
   logic [55:0] gpio_dir;
   logic [LANES-1:0] lane_en;
   logic [31:0] status;
   logic [31:0] prdata_d;
   logic debug_on;
   logic share_ok;
   logic first_serial_route;
   logic second_serial_route;
   logic first_tx_on;
   logic second_tx_on;
   logic video_out_share_select;
   logic [7:0] alt_sel [LANES];
   logic [7:0] alt_drive [LANES];
   logic [7:0] alt_enable [LANES];

   apb_reg_port u_apb_reg_port (
      .psel(PSEL),
      .penable(PENABLE),
      .pwrite(PWRITE),
      .paddr(PADDR),
      .sel(sel),
      .wr_en(wr_en),
      .pready(PREADY),
      .pslverr(PSLVERR)
   );

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         video_share_select_q <= VIDEO_SHARE_RST;
         debug_mode_select_q <= DEBUG_MODE_RST;
         pin_function_routing_q <= ROUTING_RST;
      end
      else if (wr_en)
      begin
         unique case (sel)
            SEL_SHARE: video_share_select_q <= PWDATA & VIDEO_SHARE_MASK;
            SEL_DEBUG: debug_mode_select_q <= PWDATA & DEBUG_MODE_MASK;
            SEL_ROUTE: pin_function_routing_q <= PWDATA & ROUTING_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         dir_low_q <= DIR_RST;
         dir_high_q <= DIR_RST;
      end
      else if (wr_en && sel == SEL_DIR_LOW)
      begin
         dir_low_q <= PWDATA & DIR_LOW_MASK;
      end
      else if (wr_en && sel == SEL_DIR_HIGH)
      begin
         dir_high_q <= PWDATA & DIR_HIGH_MASK;
      end
   end

   assign gpio_dir = {dir_high_q[23:0], dir_low_q};

   always_comb
   begin
      status = 32'h0000_0000;
      status[STATUS_LANE_LSB +: LANES] = lane_en;
      status[STATUS_FIRST_TX_BIT] = first_tx_on;
      status[STATUS_SECOND_TX_BIT] = second_tx_on;
      unique case (sel)
         SEL_SHARE: prdata_d = video_share_select_q;
         SEL_DEBUG: prdata_d = debug_mode_select_q;
         SEL_ROUTE: prdata_d = pin_function_routing_q;
         SEL_STATUS: prdata_d = status;
         SEL_DIR_LOW: prdata_d = dir_low_q;
         SEL_DIR_HIGH: prdata_d = dir_high_q;
         SEL_NONE: prdata_d = 32'h0000_0000;
      endcase
   end

   // Read data is combinational from registers, valid in the access cycle
   assign PRDATA = (PSEL && !PWRITE) ? prdata_d : 32'h0000_0000;

   assign debug_on = debug_mode_select_q[DEBUG_BIT];
   assign video_out_share_select = pin_function_routing_q[VIDEO_OUT_SHARE_BIT];
   assign first_serial_route = pin_function_routing_q[FIRST_SERIAL_BIT];
   assign second_serial_route = pin_function_routing_q[SECOND_SERIAL_BIT];
   assign share_ok = video_share_select_q[VIDEO_IN_OUT_SHARE_BIT] == VIDEO_SHARE_POLARITY;

   assign second_tx_on = second_serial_route && !video_out_share_select && !debug_on;
   assign first_tx_on = first_serial_route && !video_out_share_select && !debug_on;

   always_comb
   begin
      lane_en[LANE_VO2] = !debug_on && pin_function_routing_q[GPIO_VO2_BIT];
      lane_en[LANE_VO1] = pin_function_routing_q[GPIO_VO1_BIT] && share_ok;
      lane_en[LANE_VO0] = pin_function_routing_q[GPIO_VO0_BIT] && share_ok;
      lane_en[LANE_VI3] = !debug_on && (pin_function_routing_q[SECOND_SERIAL_BIT:
         VIDEO_OUT_SHARE_BIT] == SERIAL_FIELD_CLEAR);
      lane_en[LANE_VI2] = !debug_on && !pin_function_routing_q[VIDEO_IN2_SHARE_BIT];
      lane_en[LANE_VI1] = !debug_on;
      lane_en[LANE_VO3] = pin_function_routing_q[GPIO_VO3_LSB +: 3] == GPIO_VO3_CODE;
   end

   always_comb
   begin
      for (int k = 0; k < LANES; k++)
      begin
         alt_sel[k] = {8{lane_en[k]}};
         alt_drive[k] = GPIO_DRIVE[k*8 +: 8];
         alt_enable[k] = gpio_dir[k*8 +: 8];
      end
      // Receive pins are never driven; the video-in pad is already an input
      if (second_serial_route)
      begin
         alt_sel[LANE_VI3][SECOND_RX_PIN] = 1'b1;
         alt_enable[LANE_VI3][SECOND_RX_PIN] = 1'b0;
      end
      if (first_serial_route)
      begin
         alt_sel[LANE_VI3][FIRST_RX_PIN] = 1'b1;
         alt_enable[LANE_VI3][FIRST_RX_PIN] = 1'b0;
      end
      if (second_tx_on)
      begin
         alt_sel[LANE_VI3][SECOND_TX_PIN] = 1'b1;
         alt_drive[LANE_VI3][SECOND_TX_PIN] = SECOND_SERIAL_TRANSMIT;
         alt_enable[LANE_VI3][SECOND_TX_PIN] = 1'b1;
      end
      if (first_tx_on)
      begin
         alt_sel[LANE_VI3][FIRST_TX_PIN] = 1'b1;
         alt_drive[LANE_VI3][FIRST_TX_PIN] = FIRST_SERIAL_TRANSMIT;
         alt_enable[LANE_VI3][FIRST_TX_PIN] = 1'b1;
      end
   end

   for (genvar k = 0; k < LANES; k++)
   begin : g_lane
      pad_lane_mux #(
         .VIDEO_IS_OUTPUT(LANE_IS_VIDEO_OUT[k])
      ) u_pad_lane_mux (
         .clk(CORE_CLK),
         .rst_n(NRST),
         .alt_sel(alt_sel[k]),
         .video_drive(VIDEO_DRIVE[k]),
         .alt_drive(alt_drive[k]),
         .alt_enable(alt_enable[k]),
         .pad(SHARED_PAD[k])
      );
   end

   // sensed values read zero on lanes not given to general-purpose use
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         GPIO_SENSE <= 56'h00_0000_0000_0000;
      end
      else
      begin
         for (int k = 0; k < LANES; k++)
         begin
            GPIO_SENSE[k*8 +: 8] <= lane_en[k] ? SHARED_PAD_IN[k] : 8'h00;
         end
      end
   end

   // Receivers idle high while unrouted so the engines see no start bit
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         FIRST_SERIAL_RECEIVE <= 1'b1;
         SECOND_SERIAL_RECEIVE <= 1'b1;
      end
      else
      begin
         // receive needs only its route bit
         FIRST_SERIAL_RECEIVE <= first_serial_route ?
            SHARED_PAD_IN[LANE_VI3][FIRST_RX_PIN] : 1'b1;
         // receive needs only its route bit
         SECOND_SERIAL_RECEIVE <= second_serial_route ?
            SHARED_PAD_IN[LANE_VI3][SECOND_RX_PIN] : 1'b1;
      end
   end

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!NRST);

   sequence s_route_write;
      PSEL && PENABLE && PWRITE && PADDR == ROUTING_ADDR;
   endsequence

   a_route_write_lands: assert property (
      s_route_write |=> pin_function_routing_q == ($past(PWDATA) & ROUTING_MASK))
      else $error("routing register did not take the written value");

   a_second_tx_route: assert property (
      (second_serial_route && !video_out_share_select && !debug_on)
      |=> SHARED_PAD[LANE_VI3].enable[SECOND_TX_PIN]
      && SHARED_PAD[LANE_VI3].drive[SECOND_TX_PIN] == $past(SECOND_SERIAL_TRANSMIT))
      else $error("second serial transmit not on its pad");

   a_first_rx_route: assert property (
      first_serial_route |=> FIRST_SERIAL_RECEIVE == $past(SHARED_PAD_IN[LANE_VI3][FIRST_RX_PIN]))
      else $error("first serial receive not taken from its pad");

   a_tx_share_block: assert property (
      video_out_share_select |=> !SHARED_PAD[LANE_VI3].enable[FIRST_TX_PIN]
      && !SHARED_PAD[LANE_VI3].enable[SECOND_TX_PIN])
      else $error("transmit pad driven while video-out share bit set");

   a_debug_blocks_lanes: assert property (
      debug_on |=> GPIO_SENSE[47:24] == 24'h00_0000 && GPIO_SENSE[7:0] == 8'h00)
      else $error("debug-gated lane active in debug mode");

   a_vo2_lane_dir: assert property (
      (!debug_on && pin_function_routing_q[GPIO_VO2_BIT])
      |=> SHARED_PAD[LANE_VO2].enable == $past(dir_low_q[7:0])
      && SHARED_PAD[LANE_VO2].drive == $past(GPIO_DRIVE[7:0]))
      else $error("video-out-2 lane not carrying pins 7..0");

   a_vo1_lane_dir: assert property (
      (pin_function_routing_q[GPIO_VO1_BIT] && share_ok)
      |=> SHARED_PAD[LANE_VO1].enable == $past(dir_low_q[15:8]))
      else $error("video-out-1 lane direction wrong");

   a_vo0_lane_dir: assert property (
      (pin_function_routing_q[GPIO_VO0_BIT] && share_ok)
      |=> SHARED_PAD[LANE_VO0].enable == $past(dir_low_q[23:16]))
      else $error("video-out-0 lane direction wrong");

   a_vi3_lane_sense: assert property (
      (!debug_on && pin_function_routing_q[19:17] == SERIAL_FIELD_CLEAR)
      |=> GPIO_SENSE[31:24] == $past(SHARED_PAD_IN[LANE_VI3])
      && SHARED_PAD[LANE_VI3].enable == $past(dir_low_q[31:24]))
      else $error("video-in-3 lane not carrying pins 31..24");

   a_vi2_lane_sense: assert property (
      (!debug_on && !pin_function_routing_q[VIDEO_IN2_SHARE_BIT])
      |=> GPIO_SENSE[39:32] == $past(SHARED_PAD_IN[LANE_VI2]))
      else $error("video-in-2 lane not carrying pins 39..32");

   a_vi1_lane_dir: assert property (
      !debug_on |=> SHARED_PAD[LANE_VI1].enable == $past(dir_high_q[15:8]))
      else $error("video-in-1 lane direction wrong");

   a_vo3_lane_dir: assert property (
      lane_en[LANE_VO3] |=> SHARED_PAD[LANE_VO3].enable == $past(dir_high_q[23:16])
      && SHARED_PAD[LANE_VO3].drive == $past(GPIO_DRIVE[55:48]))
      else $error("video-out-3 lane direction wrong");

   a_vo3_video_kept: assert property (
      !lane_en[LANE_VO3] |=> SHARED_PAD[LANE_VO3].enable == 8'hFF
      && SHARED_PAD[LANE_VO3].drive == $past(VIDEO_DRIVE[LANE_VO3]))
      else $error("video-out-3 pads left video function while unshared");

endmodule
`default_nettype wire

/* video_port_pin_sharing_mux_tb.sv */
// Self-checking bench for the pin sharing block: APB registers, lane
// selection, serial routing, pad direction and reset state.
// Assumes one 40 MHz clock and the default share polarity of the design.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) \
   begin \
      checks_done++; \
      if ((ex) !== (gt)) \
      begin \
         failures++; \
         $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
      end \
   end
module video_port_pin_sharing_mux_tb
   import pin_share_pkg::*;
   ;
   logic core_clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic [7:0] pad_in [LANES];
   logic [7:0] video_drive [LANES];
   pad_lane_t pad [LANES];
   logic [55:0] gpio_drive, gpio_sense;
   logic tx0, rx0, tx1, rx1;
   logic [31:0] sh_m, dbg_m, rt_m, dl_m, dh_m;
   int failures, checks_done, cycles, seed;
   logic [31:0] rd_v;
   logic err_v;

   video_port_pin_sharing_mux u_dut (
      .CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .SHARED_PAD_IN(pad_in),
      .SHARED_PAD(pad), .VIDEO_DRIVE(video_drive), .GPIO_DRIVE(gpio_drive),
      .GPIO_SENSE(gpio_sense), .FIRST_SERIAL_TRANSMIT(tx0),
      .FIRST_SERIAL_RECEIVE(rx0), .SECOND_SERIAL_TRANSMIT(tx1),
      .SECOND_SERIAL_RECEIVE(rx1)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic complete_run();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard, well above the roughly 1500 cycles the run needs
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         complete_run();
      end
   end

   function automatic logic lane_on(int k);
      logic lo, vis;
      lo = !dbg_m[DEBUG_BIT];
      vis = sh_m[VIDEO_IN_OUT_SHARE_BIT] == 1'b1;
      case (k)
         LANE_VO2: return lo && rt_m[GPIO_VO2_BIT];
         LANE_VO1: return vis && rt_m[GPIO_VO1_BIT];
         LANE_VO0: return vis && rt_m[GPIO_VO0_BIT];
         LANE_VI3: return lo && rt_m[19:17] == 3'h0;
         LANE_VI2: return lo && !rt_m[VIDEO_IN2_SHARE_BIT];
         LANE_VI1: return lo;
         default: return rt_m[23:21] == 3'h1;
      endcase
   endfunction

   function automatic logic tx_on(int bitpos);
      return rt_m[bitpos] && !rt_m[VIDEO_OUT_SHARE_BIT] && !dbg_m[DEBUG_BIT];
   endfunction

   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      // Waits for the slave; only the bench's cycle ceiling ends a hang
      while (pready !== 1'b1)
      begin
         @(posedge core_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] addr, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, addr, d, rd, err);
      `CHK("write error", 1'b0, err)
      case (addr)
         VIDEO_SHARE_ADDR: sh_m = d & VIDEO_SHARE_MASK;
         DEBUG_MODE_ADDR: dbg_m = d & DEBUG_MODE_MASK;
         ROUTING_ADDR: rt_m = d & ROUTING_MASK;
         DIR_LOW_ADDR: dl_m = d & DIR_LOW_MASK;
         DIR_HIGH_ADDR: dh_m = d & DIR_HIGH_MASK;
         default: ;
      endcase
   endtask

   task automatic rd_chk(input logic [31:0] addr, input logic [31:0] ex, input logic er);
      logic [31:0] rd;
      logic err;
      apb(1'b0, addr, 32'h0000_0000, rd, err);
      `CHK("read data", ex, rd)
      `CHK("read error", er, err)
   endtask

   task automatic read_regs();
      rd_chk(VIDEO_SHARE_ADDR, sh_m, 1'b0);
      rd_chk(DEBUG_MODE_ADDR, dbg_m, 1'b0);
      rd_chk(ROUTING_ADDR, rt_m, 1'b0);
      rd_chk(DIR_LOW_ADDR, dl_m, 1'b0);
      rd_chk(DIR_HIGH_ADDR, dh_m, 1'b0);
   endtask

   task automatic reset_model();
      sh_m = VIDEO_SHARE_RST;
      dbg_m = DEBUG_MODE_RST;
      rt_m = ROUTING_RST;
      dl_m = DIR_RST;
      dh_m = DIR_RST;
   endtask

   task automatic check_all();
      logic [7:0] en_x, dr_x;
      logic [55:0] dir;
      logic [31:0] st;
      dir = {dh_m[23:0], dl_m};
      st = 32'h0000_0000;
      repeat (2) @(posedge core_clk);
      #1;
      for (int k = 0; k < LANES; k++)
      begin
         st[k] = lane_on(k);
         if (lane_on(k))
         begin
            en_x = dir[8*k +: 8];
            dr_x = gpio_drive[8*k +: 8];
         end
         else if (LANE_IS_VIDEO_OUT[k])
         begin
            en_x = 8'hFF;
            dr_x = video_drive[k];
         end
         else
         begin
            en_x = (k == LANE_VI3) ? {4'h0, tx_on(19), 1'b0, tx_on(18), 1'b0} : 8'h00;
            dr_x = {4'h0, tx1, 1'b0, tx0, 1'b0};
         end
         `CHK("pad enable", en_x, pad[k].enable)
         `CHK("pad drive", dr_x & en_x, pad[k].drive & en_x)
         `CHK("gpio sense", lane_on(k) ? pad_in[k] : 8'h00, gpio_sense[8*k +: 8])
      end
      `CHK("first rx", rt_m[18] ? pad_in[LANE_VI3][0] : 1'b1, rx0)
      `CHK("second rx", rt_m[19] ? pad_in[LANE_VI3][2] : 1'b1, rx1)
      st[STATUS_FIRST_TX_BIT] = tx_on(18);
      st[STATUS_SECOND_TX_BIT] = tx_on(19);
      rd_chk(ROUTE_STATUS_ADDR, st, 1'b0);
   endtask

   task automatic random_inputs();
      logic [63:0] g;
      g = {$random(seed), $random(seed)};
      @(posedge core_clk);
      for (int k = 0; k < LANES; k++)
      begin
         pad_in[k] <= 8'($random(seed));
         video_drive[k] <= 8'($random(seed));
      end
      gpio_drive <= g[55:0];
      tx0 <= 1'($random(seed));
      tx1 <= 1'($random(seed));
   endtask

   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      gpio_drive = 56'h0;
      tx0 = 1'b0;
      tx1 = 1'b0;
      for (int k = 0; k < LANES; k++)
      begin
         pad_in[k] = 8'h00;
         video_drive[k] = 8'h00;
      end
      failures = 0;
      checks_done = 0;
      seed = 83;
      reset_model();
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      random_inputs();
      check_all();
      read_regs();
      // Host programs the sharing bits only after reset
      wr(VIDEO_SHARE_ADDR, 32'hFFFF_FFFF);
      wr(DEBUG_MODE_ADDR, 32'hFFFF_FFFF);
      wr(ROUTING_ADDR, 32'hFFFF_FFFF);
      wr(DIR_LOW_ADDR, 32'hFFFF_FFFF);
      wr(DIR_HIGH_ADDR, 32'hFFFF_FFFF);
      read_regs();
      check_all();
      apb(1'b1, 32'h8000_140C, 32'hFFFF_FFFF, rd_v, err_v);
      `CHK("unmapped write", 1'b1, err_v)
      read_regs();
      rd_chk(32'h8000_140C, 32'h0000_0000, 1'b1);
      wr(DEBUG_MODE_ADDR, 32'h0000_0000);
      for (int c = 0; c < 8; c++)
      begin
         random_inputs();
         wr(ROUTING_ADDR, 32'(c) << 21);
         check_all();
         wr(ROUTING_ADDR, (32'(c) << 17) | 32'h0001_0000);
         check_all();
      end
      repeat (60)
      begin
         random_inputs();
         wr(VIDEO_SHARE_ADDR, $random(seed));
         wr(DEBUG_MODE_ADDR, $random(seed));
         wr(ROUTING_ADDR, $random(seed));
         wr(DIR_LOW_ADDR, $random(seed));
         wr(DIR_HIGH_ADDR, $random(seed));
         check_all();
      end
      // Reset again in mid-run; every lane must fall back to video
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("rx in reset", 2'b11, {rx1, rx0})
      `CHK("vo2 in reset", 8'hFF, pad[LANE_VO2].enable)
      reset_model();
      @(posedge core_clk);
      nrst <= 1'b1;
      check_all();
      read_regs();
      complete_run();
   end
endmodule
`default_nettype wire
